// ==== bench/laib_exec_assertions.sv ====
// Port assertions for the execute slice.
// Assumes one clock domain and an active-low reset.
`timescale 1ns/1ps
`default_nettype none
module laib_exec_assertions (
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic        instr_valid,
   input wire logic [31:0] instr_word,
   input wire logic [31:0] source_register_a_val,
   input wire logic [31:0] source_or_dest_register_b_val,
   input wire logic [31:0] instr_pc,
   input wire logic [31:0] reg_wr_data,
   input wire logic [31:0] next_pc,
   input wire logic        pc_load,
   input wire logic        reg_wr_en,
   input wire logic        instr_handled,
   input wire logic        branch_taken
);
   wire        v  = instr_valid;
   wire [5:0]  op = instr_word[5:0];
   wire [15:0] im = instr_word[21:6];
   wire [31:0] a  = source_register_a_val;
   wire [31:0] b  = source_or_dest_register_b_val;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_andhi; v && op == 6'h2C |=> reg_wr_data == $past(a & {im, 16'h0000}); endproperty
   a_andhi: assert property (p_andhi) else $error("andhi result");
   property p_andi; v && op == 6'h0C |=> reg_wr_data == $past(a & {16'h0000, im}); endproperty
   a_andi: assert property (p_andi) else $error("andi result");
   property p_beq; v && op == 6'h26 |=> branch_taken == $past(a == b); endproperty
   a_beq: assert property (p_beq) else $error("beq decision");
   property p_bne; v && op == 6'h1E |=> branch_taken == $past(a != b); endproperty
   a_bne: assert property (p_bne) else $error("bne decision");
   property p_bge; v && op == 6'h0E |=> branch_taken == $past($signed(a) >= $signed(b)); endproperty
   a_bge: assert property (p_bge) else $error("bge decision");
   property p_bgeu; v && op == 6'h2E |=> branch_taken == $past(a >= b); endproperty
   a_bgeu: assert property (p_bgeu) else $error("bgeu decision");
   property p_blt; v && op == 6'h16 |=> branch_taken == $past($signed(a) < $signed(b)); endproperty
   a_blt: assert property (p_blt) else $error("blt decision");
   property p_bltu; v && op == 6'h36 |=> branch_taken == $past(a < b); endproperty
   a_bltu: assert property (p_bltu) else $error("bltu decision");
   property p_target; v && (op inside {6'h26, 6'h1E, 6'h0E, 6'h2E, 6'h16, 6'h36}) |=> pc_load &&
      next_pc == (branch_taken ? $past(instr_pc + 32'h0000_0004 + {{16{im[15]}}, im})
                               : $past(instr_pc + 32'h0000_0004)); endproperty
   a_target: assert property (p_target) else $error("branch target");
   property p_refused; !(v && (op inside {6'h2C, 6'h0C, 6'h26, 6'h1E, 6'h0E, 6'h2E, 6'h16, 6'h36}))
      |=> !instr_handled && !pc_load && !reg_wr_en && !branch_taken; endproperty
   a_refused: assert property (p_refused) else $error("refused word acted on");
endmodule
bind laib_exec laib_exec_assertions i_laib_exec_assertions (.*);
`default_nettype wire

// ==== bench/laib_regfile_model.sv ====
// Register file stand-in with same-cycle reads.
// Assumes the bench loads the word array directly.
`timescale 1ns/1ps
`default_nettype none
module laib_regfile_model (
   input  wire logic [4:0]  rd_a_idx,
   input  wire logic [4:0]  rd_b_idx,
   output logic [31:0]      rd_a,
   output logic [31:0]      rd_b
);
   logic [31:0] mem [32];
   assign rd_a = mem[rd_a_idx];
   assign rd_b = mem[rd_b_idx];
endmodule
`default_nettype wire

// ==== bench/tb_logic_imm_and_cond_branch_exec.sv ====
// Random back-to-back instruction bench for the execute slice.
// Assumes the regfile model answers in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin mismatches++; \
   $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb_logic_imm_and_cond_branch_exec;
   logic        clk_sys = 1'b0, rst_n = 1'b0, instr_valid = 1'b0;
   logic [31:0] instr_word = 32'h0000_0000, instr_pc = 32'h0000_0000;
   logic [31:0] a_val, b_val, reg_wr_data, next_pc, ep, ed;
   logic [4:0]  a_idx, b_idx, reg_wr_idx, ei;
   logic        instr_handled, reg_wr_en, pc_load, branch_taken, eh, ew, el, et;
   logic [5:0]  ops [9] = '{6'h2C, 6'h0C, 6'h26, 6'h1E, 6'h0E, 6'h2E, 6'h16, 6'h36, 6'h3A};
   int          mismatches = 0, n_checks = 0, k, o;
   laib_exec i_laib_exec (.clk_sys, .rst_n, .instr_valid, .instr_word, .instr_pc,
      .source_register_a_val(a_val), .source_or_dest_register_b_val(b_val),
      .source_register_a_idx(a_idx), .source_or_dest_register_b_idx(b_idx),
      .instr_handled, .reg_wr_en, .reg_wr_idx, .reg_wr_data, .pc_load, .next_pc, .branch_taken);
   laib_regfile_model i_laib_regfile_model (.rd_a_idx(a_idx), .rd_b_idx(b_idx), .rd_a(a_val), .rd_b(b_val));
   function automatic logic take(logic [5:0] c, logic [31:0] a, logic [31:0] b);
      case (c)
         6'h26: return a == b;
         6'h1E: return a != b;
         6'h0E: return $signed(a) >= $signed(b);
         6'h2E: return a >= b;
         6'h16: return $signed(a) < $signed(b);
         default: return a < b;
      endcase
   endfunction
   task end_of_test;
      if (mismatches == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial forever #12.5 clk_sys = ~clk_sys;
   initial begin
      #50000;
      mismatches++;
      end_of_test();
   end
   initial begin
      void'($urandom(63));
      foreach (i_laib_regfile_model.mem[i]) i_laib_regfile_model.mem[i] = $urandom;
      // Sign boundary pair makes signed and unsigned compares disagree
      i_laib_regfile_model.mem[1] = 32'h8000_0000;
      i_laib_regfile_model.mem[2] = 32'h7FFF_FFFF;
      i_laib_regfile_model.mem[3] = 32'hFFFF_FFFF;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (k = 0; k < 401; k++) begin
         @(posedge clk_sys);
         o = $urandom % 9;
         instr_valid <= ($urandom % 8) != 0;
         instr_pc <= $urandom & 32'hFFFF_FFFC;
         // narrow index range also yields swapped and equal operand pairs
         // branch offsets keep their two low bits zero
         instr_word <= {2'b00, 3'($urandom % 8), 2'b00, 3'($urandom % 8),
                        16'($urandom) & (o < 2 ? 16'hFFFF : 16'hFFFC), ops[o]};
         @(negedge clk_sys);
         `CHK("a_idx", instr_word[31:27], a_idx)
         `CHK("b_idx", instr_word[26:22], b_idx)
         if (k > 0) begin
            `CHK("handled", eh, instr_handled)
            `CHK("wr_en", ew, reg_wr_en)
            `CHK("pc_load", el, pc_load)
            `CHK("taken", et, branch_taken)
            if (ew) `CHK("wr_data", ed, reg_wr_data)
            if (ew) `CHK("wr_idx", ei, reg_wr_idx)
            if (el) `CHK("next_pc", ep, next_pc)
         end
         ei = instr_word[26:22];
         eh = instr_valid && o < 8;
         ew = eh && o < 2;
         el = eh && o >= 2;
         et = el && take(ops[o], a_val, b_val);
         ed = a_val & (o == 0 ? {instr_word[21:6], 16'h0000} : {16'h0000, instr_word[21:6]});
         ep = instr_pc + 32'h0000_0004 + (et ? {{16{instr_word[21]}}, instr_word[21:6]} : 32'h0000_0000);
      end
      end_of_test();
   end
endmodule
`default_nettype wire

// ==== src/laib_branch_cond.sv ====
// Branch condition unit: compares two register words per branch opcode.
// Assumes the opcode is one of the six conditional branches, else no take.
`timescale 1ns/1ps
`default_nettype none
module laib_branch_cond (
   input  wire logic [5:0]  opcode,
   input  wire logic [31:0] src_a,
   input  wire logic [31:0] src_b,
   output logic             is_branch,
   output logic             take
);
   logic eq;
   logic lt_s;
   logic lt_u;

   assign eq   = (src_a == src_b);
   assign lt_s = ($signed(src_a) < $signed(src_b));
   assign lt_u = (src_a < src_b);

   always_comb begin
      is_branch = 1'b1;
      take      = 1'b0;
      case (opcode)
         laib_pkg::OPC_BEQ:  take = eq;
         laib_pkg::OPC_BNE:  take = !eq;
         laib_pkg::OPC_BGE:  take = !lt_s;
         laib_pkg::OPC_BGEU: take = !lt_u;
         laib_pkg::OPC_BLT:  take = lt_s;
         laib_pkg::OPC_BLTU: take = lt_u;
         default:            is_branch = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// ==== src/laib_exec.sv ====
// Execute stage slice for AND-immediate and conditional branches.
// Assumes the register file supplies operand values for the decoded indices
// in the same cycle, and that the PC logic loads next_pc when pc_load pulses.
`timescale 1ns/1ps
`default_nettype none
module laib_exec (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        instr_valid,
   input  wire logic [31:0] instr_word,
   input  wire logic [31:0] instr_pc,
   input  wire logic [31:0] source_register_a_val,
   input  wire logic [31:0] source_or_dest_register_b_val,
   output logic [4:0]       source_register_a_idx,
   output logic [4:0]       source_or_dest_register_b_idx,
   output logic             instr_handled,
   output logic             reg_wr_en,
   output logic [4:0]       reg_wr_idx,
   output logic [31:0]      reg_wr_data,
   output logic             pc_load,
   output logic [31:0]      next_pc,
   output logic             branch_taken
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      laib_pkg::laib_kind_e kind;
      logic                 wr_en;
      logic [4:0]           wr_idx;
      logic [31:0]          wr_data;
      logic                 pc_ld;
      logic [31:0]          pc_next;
      logic                 taken;
   } laib_state_s;

   laib_state_s st_r;
   laib_state_s st_nxt;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic [5:0]  opcode;
   logic [15:0] sixteen_bit_immediate;
   logic [31:0] imm_sext;
   logic [31:0] pc_seq;
   logic [31:0] pc_target;
   logic        is_branch;
   logic        take;

   assign source_register_a_idx         = instr_word[laib_pkg::REGA_MSB:laib_pkg::REGA_LSB];
   assign source_or_dest_register_b_idx = instr_word[laib_pkg::REGB_MSB:laib_pkg::REGB_LSB];
   assign sixteen_bit_immediate         = instr_word[laib_pkg::IMM_MSB:laib_pkg::IMM_LSB];
   assign opcode                        = instr_word[laib_pkg::OPC_MSB:laib_pkg::OPC_LSB];

   assign imm_sext  = {{16{sixteen_bit_immediate[15]}}, sixteen_bit_immediate};
   assign pc_seq    = instr_pc + laib_pkg::PC_STEP;
   assign pc_target = pc_seq + imm_sext;

   laib_branch_cond u_cond (
      .opcode    (opcode),
      .src_a     (source_register_a_val),
      .src_b     (source_or_dest_register_b_val),
      .is_branch (is_branch),
      .take      (take)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt         = st_r;
      st_nxt.kind    = laib_pkg::LAIB_K_NONE;
      st_nxt.wr_en   = 1'b0;
      st_nxt.pc_ld   = 1'b0;
      st_nxt.taken   = 1'b0;
      if (instr_valid) begin
         case (opcode)
            laib_pkg::OPC_ANDHI: begin
               st_nxt.kind    = laib_pkg::LAIB_K_LOGIC;
               st_nxt.wr_en   = 1'b1;
               st_nxt.wr_idx  = source_or_dest_register_b_idx;
               st_nxt.wr_data = source_register_a_val & {sixteen_bit_immediate, laib_pkg::HALF_ZERO};
            end
            laib_pkg::OPC_ANDI: begin
               st_nxt.kind    = laib_pkg::LAIB_K_LOGIC;
               st_nxt.wr_en   = 1'b1;
               st_nxt.wr_idx  = source_or_dest_register_b_idx;
               st_nxt.wr_data = source_register_a_val & {laib_pkg::HALF_ZERO, sixteen_bit_immediate};
            end
            default: begin
               if (is_branch) begin
                  st_nxt.kind    = laib_pkg::LAIB_K_BRANCH;
                  st_nxt.pc_ld   = 1'b1;
                  st_nxt.taken   = take;
                  st_nxt.pc_next = take ? pc_target : pc_seq;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_r.kind    <= laib_pkg::LAIB_K_NONE;
         st_r.wr_en   <= 1'b0;
         st_r.wr_idx  <= laib_pkg::IDX_RST;
         st_r.wr_data <= laib_pkg::WORD_RST;
         st_r.pc_ld   <= 1'b0;
         st_r.pc_next <= laib_pkg::WORD_RST;
         st_r.taken   <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign instr_handled = (st_r.kind != laib_pkg::LAIB_K_NONE);
   assign reg_wr_en     = st_r.wr_en;
   assign reg_wr_idx    = st_r.wr_idx;
   assign reg_wr_data   = st_r.wr_data;
   assign pc_load       = st_r.pc_ld;
   assign next_pc       = st_r.pc_next;
   assign branch_taken  = st_r.taken;

endmodule
`default_nettype wire

// ==== src/laib_pkg.sv ====
// Package for the AND-immediate and conditional-branch execute block.
// Assumes a 32-bit core with 32 general-purpose registers and byte addressed PC.
package laib_pkg;

   // ----------------------------------------------------------------
   // Instruction word fields
   // ----------------------------------------------------------------
   localparam int REGA_MSB = 31;
   localparam int REGA_LSB = 27;
   localparam int REGB_MSB = 26;
   localparam int REGB_LSB = 22;
   localparam int IMM_MSB  = 21;
   localparam int IMM_LSB  = 6;
   localparam int OPC_MSB  = 5;
   localparam int OPC_LSB  = 0;

   // ----------------------------------------------------------------
   // Opcodes
   // ----------------------------------------------------------------
   localparam logic [5:0] OPC_ANDHI = 6'h2C;
   localparam logic [5:0] OPC_ANDI  = 6'h0C;
   localparam logic [5:0] OPC_BEQ   = 6'h26;
   localparam logic [5:0] OPC_BNE   = 6'h1E;
   localparam logic [5:0] OPC_BGE   = 6'h0E;
   localparam logic [5:0] OPC_BGEU  = 6'h2E;
   localparam logic [5:0] OPC_BLT   = 6'h16;
   localparam logic [5:0] OPC_BLTU  = 6'h36;

   // ----------------------------------------------------------------
   // Constants and reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] PC_STEP     = 32'h0000_0004;
   localparam logic [15:0] HALF_ZERO   = 16'h0000;
   localparam logic [31:0] WORD_RST    = 32'h0000_0000;
   localparam logic [4:0]  IDX_RST     = 5'h00;

   // Kind of instruction decoded
   typedef enum logic [2:0] {
      LAIB_K_NONE   = 3'b001,
      LAIB_K_LOGIC  = 3'b010,
      LAIB_K_BRANCH = 3'b100
   } laib_kind_e;

endpackage
